// ### rtl/cfhp_pkg.sv
// Package for the coded speech frame header parser.
// Assumes one 100 MHz clock domain; offsets are Avalon-MM byte addresses.
package cfhp_pkg;
    // Clock rate
    localparam int CLK_MHZ = 100;
    // Frame sizes in bits, one per supported rate
    localparam logic [9:0] LEN_2P8  = 10'h038;  // 56 bits
    localparam logic [9:0] LEN_7P2  = 10'h090;  // 144 bits
    localparam logic [9:0] LEN_8P0  = 10'h0A0;  // 160 bits
    localparam logic [9:0] LEN_9P6  = 10'h0C0;  // 192 bits
    localparam logic [9:0] LEN_13P2 = 10'h108;  // 264 bits
    localparam logic [9:0] LEN_24P4 = 10'h1E8;  // 488 bits
    localparam int         MEM_BITS = 512;
    // Rate codes as reported in the result register
    localparam logic [2:0] RATE_NONE = 3'h0;
    localparam logic [2:0] RATE_2P8  = 3'h1;
    localparam logic [2:0] RATE_7P2  = 3'h2;
    localparam logic [2:0] RATE_8P0  = 3'h3;
    localparam logic [2:0] RATE_9P6  = 3'h4;
    localparam logic [2:0] RATE_13P2 = 3'h5;
    localparam logic [2:0] RATE_24P4 = 3'h6;
    // Core codes
    localparam logic [1:0] CORE_LP   = 2'h0;
    localparam logic [1:0] CORE_HQ   = 2'h1;
    localparam logic [1:0] CORE_EXC  = 2'h2;
    localparam logic [1:0] CORE_NONE = 2'h3;
    // Joint index and class codes that select a transform core
    localparam logic [3:0] JOINT_HQ_CODE  = 4'hF;
    localparam logic [2:0] CLS96_EXC_CODE = 3'h7;
    localparam logic [4:0] IDX13_XFM_MIN  = 5'h1C;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    localparam logic [4:0] OFS_FIELDS = 5'h0C;
    localparam logic [4:0] OFS_FRAMES = 5'h10;
    localparam logic [4:0] OFS_ERRORS = 5'h14;
    // Field positions and reset values
    localparam int         CTRL_EN_BIT   = 0;
    localparam int         STAT_BUSY_BIT = 0;
    localparam int         STAT_ERR_BIT  = 1;
    localparam logic       CTRL_EN_RST   = 1'b1;
    // Payload FIFO shape
    localparam int         FIFO_W = 9;
    localparam int         FIFO_D = 8;
    // Parser states
    typedef enum logic [1:0] {ST_RECV, ST_DECODE, ST_EMIT} cfhp_state_e;
endpackage : cfhp_pkg

// ### rtl/cfhp_parser.sv
// Frame header parser with payload FIFO and Avalon-MM register slave.
// Assumes the encoder stream and the bus master run on clock_i.
`timescale 1ns/1ps

// Synchronous FIFO with valid and ready on both sides
module cfhp_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         clock_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic      [W-1:0] out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [0:D-1];
    logic [AW:0]  cnt_r;
    logic [AW-1:0] wp_r, rp_r;
    logic          push, pop;

    assign in_ready_o  = (cnt_r != D[AW:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            if (pop) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : cfhp_fifo

module cfhp_parser (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Serial coded-parameter stream
    input  wire logic        rx_bit_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_last_i,
    output logic             rx_ready_o,
    // Payload bytes, first bit in bit 7, flag in bit 8 marks the last byte
    output logic [8:0]       pl_data_o,
    output logic             pl_valid_o,
    input  wire logic        pl_ready_i,
    // Decoded header of the latest frame
    output logic [2:0]       rate_o,
    output logic [1:0]       core_o,
    output logic             hdr_valid_o
);
    cfhp_pkg::cfhp_state_e state_r;
    logic       mem_r [0:cfhp_pkg::MEM_BITS-1];
    logic [9:0] len_r, ptr_r;
    logic       ovf_r, en_r, err_r, ack_r;
    logic [7:0] acc_r;
    logic [2:0] nb_r;
    logic       pend_r, plast_r, fin;
    logic [31:0] frames_r, errors_r;
    logic [2:0] rate_r;
    logic [1:0] core_r, tcls_r;
    logic [3:0] band_r, hlen_r;
    logic [4:0] cls_r;
    logic       act_r, prev_r, r16_r, fifo_rdy, take;
    logic [7:0] h;
    // Decode results
    logic [2:0] d_rate;
    logic [1:0] d_core, d_tcls;
    logic [3:0] d_band, d_len;
    logic [4:0] d_cls;
    logic       d_act, d_prev, d_r16, d_ok;

    // Field of n bits, first received bit becomes the MSB
    function automatic logic [4:0] fld(input logic [7:0] hb, input int s, input int n);
        logic [4:0] v;
        v = '0;
        for (int i = 0; i < 5; i++) begin
            if (i < n) v = {v[3:0], hb[s + i]};
        end
        return v;
    endfunction : fld

    assign take = rx_valid_i && rx_ready_o;
    assign rx_ready_o = (state_r == cfhp_pkg::ST_RECV);
    for (genvar g = 0; g < 8; g++) begin : g_hdr
        assign h[g] = mem_r[g];
    end

    // Bit store for the frame being received
    always_ff @(posedge clock_i) begin
        if (take && !len_r[9]) begin
            mem_r[len_r[8:0]] <= rx_bit_i;
        end
    end

    // Header decode from frame size and leading bits
    always_comb begin
        d_rate = cfhp_pkg::RATE_NONE;
        d_core = cfhp_pkg::CORE_NONE;
        d_band = '0;
        d_cls  = '0;
        d_tcls = '0;
        d_len  = '0;
        d_act  = 1'b1;
        d_prev = 1'b0;
        d_r16  = 1'b0;
        d_ok   = !ovf_r;
        case (len_r)
            cfhp_pkg::LEN_2P8: begin
                d_rate = cfhp_pkg::RATE_2P8;
                d_act  = h[0];
                d_core = h[0] ? cfhp_pkg::CORE_LP : cfhp_pkg::CORE_NONE;
                d_cls  = {4'h0, h[1]};
                d_band = {3'h0, h[2]};
                d_len  = 4'h3;
            end
            cfhp_pkg::LEN_7P2, cfhp_pkg::LEN_8P0: begin
                d_rate = (len_r == cfhp_pkg::LEN_7P2) ? cfhp_pkg::RATE_7P2
                                                       : cfhp_pkg::RATE_8P0;
                d_band = 4'(fld(h, 0, 4));
                d_cls  = fld(h, 0, 4);
                d_core = (d_band == cfhp_pkg::JOINT_HQ_CODE) ? cfhp_pkg::CORE_HQ
                                                              : cfhp_pkg::CORE_LP;
                d_len  = 4'h4;
            end
            cfhp_pkg::LEN_9P6: begin
                d_rate = cfhp_pkg::RATE_9P6;
                d_band = {2'h0, 2'(fld(h, 0, 2))};
                d_cls  = fld(h, 2, 3);
                d_core = (d_cls[2:0] == cfhp_pkg::CLS96_EXC_CODE) ? cfhp_pkg::CORE_EXC
                                                                   : cfhp_pkg::CORE_LP;
                d_len  = 4'h5;
            end
            cfhp_pkg::LEN_13P2: begin
                d_rate = cfhp_pkg::RATE_13P2;
                d_cls  = fld(h, 0, 5);
                d_band = d_cls[3:0];
                d_core = cfhp_pkg::CORE_LP;
                d_len  = 4'h5;
                if (d_cls >= cfhp_pkg::IDX13_XFM_MIN) begin
                    d_core = h[5] ? cfhp_pkg::CORE_EXC : cfhp_pkg::CORE_HQ;
                    d_len  = 4'h6;
                    if (h[5]) begin
                        d_tcls = 2'(fld(h, 6, 2));
                        d_len  = 4'h8;
                    end
                end
            end
            cfhp_pkg::LEN_24P4: begin
                d_rate = cfhp_pkg::RATE_24P4;
                d_band = {2'h0, 2'(fld(h, 0, 2))};
                if (!h[3]) begin
                    d_core = cfhp_pkg::CORE_LP;
                    d_cls  = fld(h, 4, 2);
                    d_len  = 4'h6;
                end else if (h[4]) begin
                    d_core = cfhp_pkg::CORE_EXC;
                    d_tcls = 2'(fld(h, 5, 2));
                    d_len  = 4'h7;
                end else begin
                    d_core = cfhp_pkg::CORE_HQ;
                    d_prev = h[5];
                    d_r16  = h[5] & h[6];
                    d_len  = h[5] ? 4'h7 : 4'h6;
                end
            end
            default: d_ok = 1'b0;
        endcase
    end

    // Frame sequencing
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= cfhp_pkg::ST_RECV;
        end else begin
            case (state_r)
                cfhp_pkg::ST_RECV:   if (take && rx_last_i) state_r <= cfhp_pkg::ST_DECODE;
                cfhp_pkg::ST_DECODE: state_r <= (d_ok && d_act && en_r) ? cfhp_pkg::ST_EMIT
                                                                       : cfhp_pkg::ST_RECV;
                cfhp_pkg::ST_EMIT:   if (fin) state_r <= cfhp_pkg::ST_RECV;
                default:             state_r <= cfhp_pkg::ST_RECV;
            endcase
        end
    end

    // Receive length counter, kept until the payload is out; too long a frame is flagged
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            len_r <= '0;
            ovf_r <= 1'b0;
        end else if ((state_r == cfhp_pkg::ST_DECODE && !(d_ok && d_act && en_r)) || fin) begin
            len_r <= '0;
            ovf_r <= 1'b0;
        end else if (take) begin
            if (len_r[9]) ovf_r <= 1'b1;
            else len_r <= len_r + 10'h001;
        end
    end

    // Latch decoded header
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rate_r <= cfhp_pkg::RATE_NONE;
            core_r <= cfhp_pkg::CORE_NONE;
            band_r <= '0;
            cls_r  <= '0;
            tcls_r <= '0;
            hlen_r <= '0;
            act_r  <= 1'b0;
            prev_r <= 1'b0;
            r16_r  <= 1'b0;
        end else if (state_r == cfhp_pkg::ST_DECODE) begin
            rate_r <= d_rate;
            core_r <= d_core;
            band_r <= d_band;
            cls_r  <= d_cls;
            tcls_r <= d_tcls;
            hlen_r <= d_len;
            act_r  <= d_act;
            prev_r <= d_prev;
            r16_r  <= d_r16;
        end
    end

    // Payload packing, stalls while the FIFO is full
    assign fin = pend_r && plast_r && fifo_rdy;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_r   <= '0;
            acc_r   <= '0;
            nb_r    <= '0;
            pend_r  <= 1'b0;
            plast_r <= 1'b0;
        end else if (state_r == cfhp_pkg::ST_DECODE) begin
            ptr_r <= {6'h00, d_len};
            nb_r  <= '0;
        end else if (state_r == cfhp_pkg::ST_EMIT) begin
            if (pend_r) begin
                if (fifo_rdy) pend_r <= 1'b0;
            end else begin
                acc_r   <= {acc_r[6:0], mem_r[ptr_r[8:0]]};
                ptr_r   <= ptr_r + 10'h001;
                nb_r    <= nb_r + 3'h1;
                plast_r <= (ptr_r == len_r - 10'h001);
                if (nb_r == 3'h7 || ptr_r == len_r - 10'h001) pend_r <= 1'b1;
            end
        end
    end

    // Left-align a short last byte
    logic [7:0] out_byte;
    assign out_byte = acc_r << (3'h0 - nb_r);

    cfhp_fifo #(
        .W (cfhp_pkg::FIFO_W),
        .D (cfhp_pkg::FIFO_D)
    ) u_fifo (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .in_data_i   ({plast_r, out_byte}),
        .in_valid_i  (pend_r),
        .in_ready_o  (fifo_rdy),
        .out_data_o  (pl_data_o),
        .out_valid_o (pl_valid_o),
        .out_ready_i (pl_ready_i)
    );

    // Frame and error counters; error flag set wins over clear
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frames_r <= '0;
            errors_r <= '0;
            err_r    <= 1'b0;
        end else begin
            if (state_r == cfhp_pkg::ST_DECODE) begin
                frames_r <= frames_r + 32'h1;
                if (!d_ok) errors_r <= errors_r + 32'h1;
            end
            if (state_r == cfhp_pkg::ST_DECODE && !d_ok) err_r <= 1'b1;
            else if (avs_write_i && ack_r && avs_address_i == cfhp_pkg::OFS_STATUS
                     && avs_byteenable_i[0] && avs_writedata_i[cfhp_pkg::STAT_ERR_BIT])
                err_r <= 1'b0;
        end
    end

    // Bus slave: one wait cycle, then answer
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r          <= 1'b0;
            en_r           <= cfhp_pkg::CTRL_EN_RST;
            avs_readdata_o <= '0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
            if (avs_write_i && ack_r && avs_address_i == cfhp_pkg::OFS_CTRL
                && avs_byteenable_i[0])
                en_r <= avs_writedata_i[cfhp_pkg::CTRL_EN_BIT];
            if (avs_read_i && !ack_r) begin
                case (avs_address_i)
                    cfhp_pkg::OFS_CTRL:   avs_readdata_o <= {31'h0, en_r};
                    cfhp_pkg::OFS_STATUS: avs_readdata_o <= {30'h0, err_r,
                                                             state_r != cfhp_pkg::ST_RECV};
                    cfhp_pkg::OFS_RESULT: avs_readdata_o <= {22'h0, hlen_r, act_r,
                                                             core_r, rate_r};
                    cfhp_pkg::OFS_FIELDS: avs_readdata_o <= {20'h0, r16_r, prev_r, tcls_r,
                                                             cls_r[3:0], band_r};
                    cfhp_pkg::OFS_FRAMES: avs_readdata_o <= frames_r;
                    cfhp_pkg::OFS_ERRORS: avs_readdata_o <= errors_r;
                    default:              avs_readdata_o <= 32'h0;
                endcase
            end
        end
    end

    assign rate_o      = rate_r;
    assign core_o      = core_r;
    assign hdr_valid_o = (rate_r != cfhp_pkg::RATE_NONE);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire dec = (state_r == cfhp_pkg::ST_DECODE);

    bus_answer_a: assert property ((avs_read_i || avs_write_i) && !ack_r
        |=> !avs_waitrequest_o) else $error("bus answer late");
    msb_first_a: assert property (state_r == cfhp_pkg::ST_EMIT && !pend_r
        |=> acc_r[0] == $past(mem_r[ptr_r[8:0]])) else $error("bit order wrong");
    rate_len_a: assert property (dec && len_r == cfhp_pkg::LEN_13P2
        |=> rate_o == cfhp_pkg::RATE_13P2) else $error("rate wrong");
    varrate_ok_a: assert property (dec && len_r == cfhp_pkg::LEN_2P8 && !ovf_r
        |=> !err_r || $past(err_r)) else $error("short frame rejected");
    active_bit_a: assert property (dec && len_r == cfhp_pkg::LEN_2P8 && !h[0]
        |=> core_o == cfhp_pkg::CORE_NONE && state_r == cfhp_pkg::ST_RECV)
        else $error("inactive frame emitted");
    joint_hq_a: assert property (dec && len_r == cfhp_pkg::LEN_7P2
        && 4'(fld(h, 0, 4)) == cfhp_pkg::JOINT_HQ_CODE |=> core_o == cfhp_pkg::CORE_HQ)
        else $error("joint index core wrong");
    cls_core_a: assert property (dec && len_r == cfhp_pkg::LEN_9P6
        |=> (core_o == cfhp_pkg::CORE_EXC) == (cls_r[2:0] == cfhp_pkg::CLS96_EXC_CODE))
        else $error("class core wrong");
    exc13_a: assert property (dec && len_r == cfhp_pkg::LEN_13P2 && h[5]
        && fld(h, 0, 5) >= cfhp_pkg::IDX13_XFM_MIN
        |=> core_o == cfhp_pkg::CORE_EXC && hlen_r == 4'h8) else $error("excited header wrong");
    family_a: assert property (dec && len_r == cfhp_pkg::LEN_24P4 && !h[3]
        |=> core_o == cfhp_pkg::CORE_LP) else $error("family flag ignored");
    hq_prev_a: assert property (dec && len_r == cfhp_pkg::LEN_24P4 && h[3] && !h[4]
        |=> hlen_r == (h[5] ? 4'h7 : 4'h6)) else $error("hq header length wrong");
    bad_len_a: assert property (dec && !d_ok
        |=> err_r && state_r == cfhp_pkg::ST_RECV) else $error("bad frame kept");

    cov_exc_c: cover property (dec && d_core == cfhp_pkg::CORE_EXC ##[1:600] fin);
    cov_stall_c: cover property (pend_r && !fifo_rdy);
    cov_err_c: cover property (dec && !d_ok);
endmodule : cfhp_parser

// ### verif/cfhp_enc_model.sv
// Encoder stand-in: sends one frame serially, first frame bit first, on a start pulse.
// Assumes the parser's ready handshake on the same clock; frame_i is left-aligned.
`timescale 1ns/1ps
module cfhp_enc_model (
    input  wire logic         clock_i,
    input  wire logic         nrst_i,
    input  wire logic         start_i,
    input  wire logic         slow_i,
    input  wire logic [9:0]   len_i,
    input  wire logic [511:0] frame_i,
    input  wire logic         ready_i,
    output logic              bit_o,
    output logic              valid_o,
    output logic              last_o
);
    logic [9:0] idx_r;
    logic       pause_r;
    logic       load;
    logic       take;

    // Next bit is loaded on start, after a slow gap, or right after a take
    assign take = valid_o && ready_i;
    assign load = (start_i && !valid_o && !pause_r) || pause_r || (take && !last_o && !slow_i);

    // Each bit stands until taken; the line toggles whenever valid is low
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_o <= 1'b0;
            last_o  <= 1'b0;
            bit_o   <= 1'b0;
            pause_r <= 1'b0;
            idx_r   <= '0;
        end else if (load) begin
            valid_o <= 1'b1;
            pause_r <= 1'b0;
            bit_o   <= frame_i[10'd511 - idx_r];
            last_o  <= (idx_r == len_i - 10'd1);
            idx_r   <= idx_r + 10'd1;
        end else if (take) begin
            valid_o <= 1'b0;
            last_o  <= 1'b0;
            bit_o   <= ~bit_o;
            pause_r <= !last_o;
            if (last_o) idx_r <= '0;
        end else if (!valid_o) begin
            bit_o <= ~bit_o;
        end
    end
endmodule : cfhp_enc_model

// ### verif/testbench.sv
// Self-checking bench: headers of every frame size, errors, enable, payload stall.
// Assumes the package, the parser and the encoder model are compiled first.
`timescale 1ns/1ps
module testbench;
    logic         clock_i = 1'b0;
    logic         nrst_i  = 1'b0;
    logic [4:0]   adr     = '0;
    logic         rd      = 1'b0;
    logic         wr      = 1'b0;
    logic [31:0]  wdat    = '0;
    logic [31:0]  rdat;
    logic [31:0]  q;
    logic         wrq, rx_bit, rx_val, rx_last, rx_rdy, pl_val, hdr_v;
    logic         pl_rdy  = 1'b1;
    logic         start   = 1'b0;
    logic         slow    = 1'b0;
    logic [8:0]   pl_dat;
    logic [8:0]   first_b = '0;
    logic [2:0]   rate;
    logic [1:0]   core;
    logic [9:0]   len     = '0;
    logic [511:0] frm     = '0;
    int           n_fail  = 0;
    int           n_tests = 0;
    int           cyc     = 0;
    int           n_last  = 0;
    bit           got     = 1'b0;

    cfhp_parser u_cfhp_parser (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .rx_bit_i(rx_bit),
        .rx_valid_i(rx_val), .rx_last_i(rx_last), .rx_ready_o(rx_rdy), .pl_data_o(pl_dat),
        .pl_valid_o(pl_val), .pl_ready_i(pl_rdy), .rate_o(rate), .core_o(core),
        .hdr_valid_o(hdr_v));
    cfhp_enc_model u_cfhp_enc_model (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(start),
        .slow_i(slow), .len_i(len), .frame_i(frm), .ready_i(rx_rdy), .bit_o(rx_bit),
        .valid_o(rx_val), .last_o(rx_last));

    always #5 clock_i = ~clock_i;

    // Note the first byte and count last flags as bytes are popped; cut a hang short
    always @(negedge clock_i) begin
        cyc <= cyc + 1;
        if (pl_val && pl_rdy) begin
            if (!got) first_b <= pl_dat;
            got <= !pl_dat[8];
            if (pl_dat[8]) n_last <= n_last + 1;
        end
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    // Register access: request held until waitrequest is seen low, then released
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_i);
        adr  <= a;
        wdat <= d;
        wr   <= w;
        rd   <= !w;
        do @(posedge clock_i); while (wrq);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // Send a frame of l bits led by header h of hl bits, wait until taken and drained
    task automatic frame(input logic [9:0] l, input logic [7:0] h, input int hl);
        logic [511:0] f;
        int           k;
        f = {64{8'hC5}};
        for (k = 0; k < hl; k++) f[511-k] = h[hl-1-k];
        @(posedge clock_i);
        frm   <= f;
        len   <= l;
        start <= 1'b1;
        @(posedge clock_i) start <= 1'b0;
        do @(posedge clock_i); while (!(rx_val && rx_rdy && rx_last));
        do @(posedge clock_i); while (!rx_rdy);
        repeat (12) @(negedge clock_i);
    endtask : frame

    task automatic expect_hdr(input logic [9:0] l, input logic [7:0] h, input int hl,
                              input logic [2:0] r, input logic [1:0] c, input bit e);
        int nl;
        nl = n_last;
        frame(l, h, hl);
        if (r !== cfhp_pkg::RATE_NONE) check("rate", rate, r);
        if (r !== cfhp_pkg::RATE_NONE) check("header valid", hdr_v, 1'b1);
        check("core", core, c);
        check("payload frames", n_last, nl + int'(e));
        if (e) check("first byte", first_b, {1'b0, frm[511-hl -: 8]});
    endtask : expect_hdr

    task automatic t_reset();
        check("rate at reset", rate, cfhp_pkg::RATE_NONE);
        check("core at reset", core, cfhp_pkg::CORE_NONE);
        check("header valid at reset", hdr_v, 1'b0);
        bus(1'b1, 5'h18, 32'h0000_0000);
        bus(1'b0, 5'h18, '0);
        check("unmapped read", q, 32'h0);
        bus(1'b0, cfhp_pkg::OFS_CTRL, '0);
        check("enable at reset", q[0], cfhp_pkg::CTRL_EN_RST);
    endtask : t_reset

    // Variable-rate classes, slow encoder on the short frames
    task automatic t_vrate();
        slow = 1'b1;
        expect_hdr(cfhp_pkg::LEN_2P8, 8'h05, 3, cfhp_pkg::RATE_2P8, cfhp_pkg::CORE_LP, 1);
        expect_hdr(cfhp_pkg::LEN_2P8, 8'h03, 3, cfhp_pkg::RATE_NONE, cfhp_pkg::CORE_NONE, 0);
        slow = 1'b0;
        expect_hdr(cfhp_pkg::LEN_7P2, 8'h0F, 4, cfhp_pkg::RATE_7P2, cfhp_pkg::CORE_HQ, 1);
        expect_hdr(cfhp_pkg::LEN_8P0, 8'h03, 4, cfhp_pkg::RATE_8P0, cfhp_pkg::CORE_LP, 1);
    endtask : t_vrate

    task automatic t_192();
        expect_hdr(cfhp_pkg::LEN_9P6, 8'h0F, 5, cfhp_pkg::RATE_9P6, cfhp_pkg::CORE_EXC, 1);
        expect_hdr(cfhp_pkg::LEN_9P6, 8'h0B, 5, cfhp_pkg::RATE_9P6, cfhp_pkg::CORE_LP, 1);
    endtask : t_192

    task automatic t_264();
        expect_hdr(cfhp_pkg::LEN_13P2, 8'hE6, 8, cfhp_pkg::RATE_13P2, cfhp_pkg::CORE_EXC, 1);
        bus(1'b0, cfhp_pkg::OFS_FIELDS, '0);
        check("transform class", q[9:8], 2'b10);
        expect_hdr(cfhp_pkg::LEN_13P2, 8'h3A, 6, cfhp_pkg::RATE_13P2, cfhp_pkg::CORE_HQ, 1);
        bus(1'b0, cfhp_pkg::OFS_RESULT, '0);
        check("header length", q[9:6], 4'h6);
        expect_hdr(cfhp_pkg::LEN_13P2, 8'h1B, 5, cfhp_pkg::RATE_13P2, cfhp_pkg::CORE_LP, 1);
    endtask : t_264

    task automatic t_488();
        expect_hdr(cfhp_pkg::LEN_24P4, 8'h13, 6, cfhp_pkg::RATE_24P4, cfhp_pkg::CORE_LP, 1);
        expect_hdr(cfhp_pkg::LEN_24P4, 8'h2D, 7, cfhp_pkg::RATE_24P4, cfhp_pkg::CORE_EXC, 1);
        bus(1'b0, cfhp_pkg::OFS_FIELDS, '0);
        check("transform class", q[9:8], 2'b01);
        expect_hdr(cfhp_pkg::LEN_24P4, 8'h2B, 7, cfhp_pkg::RATE_24P4, cfhp_pkg::CORE_HQ, 1);
        bus(1'b0, cfhp_pkg::OFS_FIELDS, '0);
        check("prev and rate bits", q[11:10], 2'b11);
        expect_hdr(cfhp_pkg::LEN_24P4, 8'h14, 6, cfhp_pkg::RATE_24P4, cfhp_pkg::CORE_HQ, 1);
        bus(1'b0, cfhp_pkg::OFS_RESULT, '0);
        check("header length", q[9:6], 4'h6);
    endtask : t_488

    // Unknown size, sticky error clear, and frames withheld while disabled
    task automatic t_err();
        int nl;
        nl = n_last;
        frame(10'd100, 8'h01, 1);
        bus(1'b0, cfhp_pkg::OFS_STATUS, '0);
        check("error flag", q[cfhp_pkg::STAT_ERR_BIT], 1'b1);
        bus(1'b0, cfhp_pkg::OFS_ERRORS, '0);
        check("error count", q, 32'h1);
        check("header valid after bad frame", hdr_v, 1'b0);
        bus(1'b1, cfhp_pkg::OFS_STATUS, 32'h2);
        bus(1'b0, cfhp_pkg::OFS_STATUS, '0);
        check("error cleared", q[cfhp_pkg::STAT_ERR_BIT], 1'b0);
        bus(1'b1, cfhp_pkg::OFS_CTRL, 32'h0);
        frame(cfhp_pkg::LEN_7P2, 8'h03, 4);
        check("no payload", n_last, nl);
        bus(1'b1, cfhp_pkg::OFS_CTRL, 32'h1);
    endtask : t_err

    // Payload sink stalls until the FIFO is full, then drains it
    task automatic t_stall();
        int nl;
        nl = n_last;
        @(posedge clock_i) pl_rdy <= 1'b0;
        fork
            frame(cfhp_pkg::LEN_24P4, 8'h13, 6);
            begin
                repeat (700) @(negedge clock_i);
                check("full fifo valid", pl_val, 1'b1);
                check("receiver held", rx_rdy, 1'b0);
                @(posedge clock_i) pl_rdy <= 1'b1;
            end
        join
        check("stalled frame out", n_last, nl + 1);
        check("first byte", first_b, {1'b0, frm[505 -: 8]});
    endtask : t_stall

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_reset();
        t_vrate();
        t_192();
        t_264();
        t_488();
        t_err();
        t_stall();
        finish_test();
    end
endmodule : testbench
